// ---- design/tmr_irq_pkg.sv ----
// Purpose: constants and carriers for the timer interrupt flag block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   flag layout shared by raw, mask, masked and clear views
package tmr_irq_pkg;

  localparam int unsigned ADDR_W   = 6;
  localparam int unsigned FLAG_W   = 11;

  // Register byte offsets
  localparam logic [5:0] OFS_RAW    = 6'h1C;
  localparam logic [5:0] OFS_MASK   = 6'h18;
  localparam logic [5:0] OFS_MASKED = 6'h20;
  localparam logic [5:0] OFS_CLEAR  = 6'h24;
  localparam logic [5:0] OFS_EVT    = 6'h30;
  localparam logic [5:0] OFS_EVTMSK = 6'h34;

  // Flag positions
  localparam int unsigned BIT_TA_TIMEOUT = 0;
  localparam int unsigned BIT_CA_MATCH   = 1;
  localparam int unsigned BIT_CA_EVENT   = 2;
  localparam int unsigned BIT_RTC        = 3;
  localparam int unsigned BIT_TB_TIMEOUT = 8;
  localparam int unsigned BIT_CB_MATCH   = 9;
  localparam int unsigned BIT_CB_EVENT   = 10;

  // Implemented flag bits; 7:4 and 31:11 are reserved
  localparam logic [10:0] FLAG_IMPL  = 11'h70F;
  localparam logic [10:0] FLAG_RESET = 11'h000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } bus_req_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DONE = 1'b1
  } bus_state_t;

endpackage

// ---- design/flag_bank.sv ----
// Purpose: sticky flag bank with set-over-clear priority
// Assumes: set and clear pulses on ref_clk
// Notes:   one flop per bit, generated
`timescale 1ns/1ps
`default_nettype none
module flag_bank (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Set and clear
  input  wire logic [10:0] set,
  input  wire logic [10:0] clear,
  // State
  output var  logic [10:0] flags
);

  genvar i;
  generate
    for (i = 0; i < 11; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          flags[i] <= 1'b0;
        end else if (set[i]) begin
          flags[i] <= 1'b1;
        end else if (clear[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- design/timer_interrupt_status_clear.sv ----
// Purpose: interrupt flags of a general timer module with W1C clear
// Assumes: source events are one-cycle pulses on ref_clk
// Notes:   Avalon-MM slave, one waitstate on every access
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_interrupt_status_clear (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  // Source events from the timer core
  input  wire logic [10:0] source_event,
  // Level outputs
  output var  logic [10:0] timer_masked_interrupt_status,
  output var  logic        timer_irq,
  output var  logic        irq
);

  // Register state
  logic [10:0] timer_interrupt_mask;
  logic [10:0] timer_raw_interrupt_status;
  logic [10:0] evt_status;
  logic [10:0] evt_mask;
  tmr_irq_pkg::bus_state_t state;
  tmr_irq_pkg::bus_req_t   req;

  // Current request bundled; the master holds it until waitrequest drops
  assign req = '{read: read, write: write, address: address,
                 writedata: writedata};

  // Decode
  wire logic        access   = req.read | req.write;
  wire logic        accept   = access & (state == tmr_irq_pkg::ST_IDLE);
  wire logic        wr_fire  = accept & req.write;
  wire logic        rd_fire  = accept & req.read;
  wire logic [10:0] wr_low   = {byteenable[1] ? req.writedata[10:8] : 3'h0,
                                byteenable[0] ? req.writedata[7:0]  : 8'h00};

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  wire logic sel_raw    = hit(req.address, tmr_irq_pkg::OFS_RAW);
  wire logic sel_mask   = hit(req.address, tmr_irq_pkg::OFS_MASK);
  wire logic sel_masked = hit(req.address, tmr_irq_pkg::OFS_MASKED);
  wire logic sel_clear  = hit(req.address, tmr_irq_pkg::OFS_CLEAR);
  wire logic sel_evt    = hit(req.address, tmr_irq_pkg::OFS_EVT);
  wire logic sel_evtmsk = hit(req.address, tmr_irq_pkg::OFS_EVTMSK);

  // One strobe per flag; zeros and reserved bits take no clear
  wire logic clear_hit = wr_fire & sel_clear;
  wire logic timer_a_timeout_clear_bit =
    clear_hit & wr_low[tmr_irq_pkg::BIT_TA_TIMEOUT];
  wire logic capture_a_match_clear_bit =
    clear_hit & wr_low[tmr_irq_pkg::BIT_CA_MATCH];
  wire logic capture_a_event_clear_bit =
    clear_hit & wr_low[tmr_irq_pkg::BIT_CA_EVENT];
  wire logic rtc_event_clear_bit =
    clear_hit & wr_low[tmr_irq_pkg::BIT_RTC];
  wire logic timer_b_timeout_clear_bit =
    clear_hit & wr_low[tmr_irq_pkg::BIT_TB_TIMEOUT];
  wire logic capture_b_match_clear_bit =
    clear_hit & wr_low[tmr_irq_pkg::BIT_CB_MATCH];
  wire logic capture_b_event_clear_bit =
    clear_hit & wr_low[tmr_irq_pkg::BIT_CB_EVENT];
  wire logic [10:0] raw_clear = {capture_b_event_clear_bit,
    capture_b_match_clear_bit, timer_b_timeout_clear_bit, 4'h0,
    rtc_event_clear_bit, capture_a_event_clear_bit,
    capture_a_match_clear_bit, timer_a_timeout_clear_bit};

  // Raw flags set regardless of mask
  wire logic [10:0] raw_set =
    source_event & tmr_irq_pkg::FLAG_IMPL;

  // Masked view derived from raw, so one clear covers both
  wire logic timer_a_timeout_masked_flag =
    timer_raw_interrupt_status[tmr_irq_pkg::BIT_TA_TIMEOUT] &
    timer_interrupt_mask[tmr_irq_pkg::BIT_TA_TIMEOUT];
  wire logic capture_a_match_masked_flag =
    timer_raw_interrupt_status[tmr_irq_pkg::BIT_CA_MATCH] &
    timer_interrupt_mask[tmr_irq_pkg::BIT_CA_MATCH];
  wire logic capture_a_event_masked_flag =
    timer_raw_interrupt_status[tmr_irq_pkg::BIT_CA_EVENT] &
    timer_interrupt_mask[tmr_irq_pkg::BIT_CA_EVENT];
  wire logic rtc_event_masked_flag =
    timer_raw_interrupt_status[tmr_irq_pkg::BIT_RTC] &
    timer_interrupt_mask[tmr_irq_pkg::BIT_RTC];
  wire logic timer_b_timeout_masked_flag =
    timer_raw_interrupt_status[tmr_irq_pkg::BIT_TB_TIMEOUT] &
    timer_interrupt_mask[tmr_irq_pkg::BIT_TB_TIMEOUT];
  wire logic capture_b_match_masked_flag =
    timer_raw_interrupt_status[tmr_irq_pkg::BIT_CB_MATCH] &
    timer_interrupt_mask[tmr_irq_pkg::BIT_CB_MATCH];
  wire logic capture_b_event_masked_flag =
    timer_raw_interrupt_status[tmr_irq_pkg::BIT_CB_EVENT] &
    timer_interrupt_mask[tmr_irq_pkg::BIT_CB_EVENT];
  wire logic [10:0] masked_now = {capture_b_event_masked_flag,
    capture_b_match_masked_flag, timer_b_timeout_masked_flag, 4'h0,
    rtc_event_masked_flag, capture_a_event_masked_flag,
    capture_a_match_masked_flag, timer_a_timeout_masked_flag};

  // Bus event status: every implemented source event sets it, a read of it clears it
  wire logic [10:0] evt_set   = raw_set;
  wire logic [10:0] evt_clear = (rd_fire & sel_evt) ? 11'h7FF : 11'h000;

  flag_bank u_raw (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .set     (raw_set),
    .clear   (raw_clear),
    .flags   (timer_raw_interrupt_status)
  );

  flag_bank u_evt (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .set     (evt_set),
    .clear   (evt_clear),
    .flags   (evt_status)
  );

  // Read mux; reserved and unmapped read zero
  wire logic [10:0] rd_flags =
      sel_raw    ? timer_raw_interrupt_status :
      sel_mask   ? timer_interrupt_mask :
      sel_masked ? masked_now :
      sel_evt    ? evt_status :
      sel_evtmsk ? evt_mask : 11'h000;

  wire logic [31:0] next_readdata = {21'h000000, rd_flags};

  // One waitstate: wait high on first cycle of each access
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= tmr_irq_pkg::ST_IDLE;
    end else begin
      unique case (state)
        tmr_irq_pkg::ST_IDLE: begin
          if (access) begin
            state <= tmr_irq_pkg::ST_DONE;
          end
        end
        tmr_irq_pkg::ST_DONE: begin
          state <= tmr_irq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Waitrequest from a flop: high unless the answer is being given
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~accept;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= tmr_irq_pkg::DATA_RESET;
    end else if (rd_fire) begin
      readdata <= next_readdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_interrupt_mask <= tmr_irq_pkg::FLAG_RESET;
    end else if (wr_fire & sel_mask) begin
      timer_interrupt_mask <= wr_low & tmr_irq_pkg::FLAG_IMPL;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evt_mask <= tmr_irq_pkg::FLAG_RESET;
    end else if (wr_fire & sel_evtmsk) begin
      evt_mask <= wr_low & tmr_irq_pkg::FLAG_IMPL;
    end
  end

  // Outputs registered; one cycle behind the flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_masked_interrupt_status <= tmr_irq_pkg::FLAG_RESET;
    end else begin
      timer_masked_interrupt_status <= masked_now;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |masked_now;
    end
  end

  // Level until software reads the status, not a pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

endmodule
`default_nettype wire

// ---- test/tisc_chk.sv ----
// Purpose: port assertions for the timer interrupt flag block
// Assumes: one waitstate per access
// Notes:   masked view lags the raw flags by one cycle
`timescale 1ns/1ps
`default_nettype none
module tisc_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // Bus
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Flags
  input wire logic [10:0] source_event,
  input wire logic [10:0] timer_masked_interrupt_status,
  input wire logic        timer_irq
);
  wire logic [10:0] ms = timer_masked_interrupt_status;
  wire logic        tk = (read | write) & waitrequest;
  wire logic        at = address == tmr_irq_pkg::OFS_CLEAR;
  // Only lanes 0 and 1 reach the flags
  wire logic [10:0] be = {{3{byteenable[1]}}, {8{byteenable[0]}}};
  wire logic [10:0] cm = writedata[10:0] & be;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_ack; tk |=> !waitrequest ##1 waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bad waitstate");
  // A new event in the clearing cycle wins, so it is excluded
  property p_clr;
    tk & write & at & ~|source_event |=> ##1 ~|(ms & $past(cm, 2));
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_rd; tk & read & at |=> readdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("clear reg not zero");
  property p_rsv; ms[7:4] == 4'h0 && readdata[31:11] == 21'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_irq; timer_irq == |ms; endproperty
  a_irq: assert property (p_irq) else $error("irq not OR of masked");
  property p_cae;
    $rose(ms[2]) |-> $past(source_event[2], 2) || $past(write, 2);
  endproperty
  a_cae: assert property (p_cae) else $error("bit 2 rose alone");
  property p_cam; $fell(ms[1]) |-> $past(write, 2); endproperty
  a_cam: assert property (p_cam) else $error("bit 1 fell alone");
  c_clr: cover property (tk & write & at);
  c_rd: cover property (tk & read & at);
  c_irq: cover property ($fell(timer_irq));
endmodule
`default_nettype wire

// ---- test/test_timer_interrupt_status_clear.sv ----
// Purpose: register level test of the timer interrupt flag block
// Assumes: one access at a time, events as single pulses
// Notes:   pin checks follow a read so outputs have settled
`timescale 1ns/1ps
`default_nettype none
module test_timer_interrupt_status_clear;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [5:0]  address = 6'h00;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rdat;
  logic [10:0] source_event = 11'h000;
  logic [10:0] timer_masked_interrupt_status;
  logic        waitrequest, timer_irq, irq;
  int          mismatches = 0;
  int          cmp_count = 0;
  timer_interrupt_status_clear timer_interrupt_status_clear_i (.ref_clk,
    .rstn, .address, .read, .write, .byteenable, .writedata, .readdata,
    .waitrequest, .source_event, .timer_masked_interrupt_status,
    .timer_irq, .irq);
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    // Called just after a rising edge; no timeout here, only the watchdog ends a stuck wait
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rdat = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // Idle edge so a following call never drives a signal twice at once
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic ev(input logic [10:0] v);
    @(posedge ref_clk);
    source_event <= v;
    @(posedge ref_clk);
    source_event <= 11'h000;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(6'h24, 32'h0);
    rd(6'h20, 32'h0);
    bus(1'b1, 6'h18, 32'h70F);
    ev(11'h7FF);
    rd(6'h1C, 32'h70F);
    rd(6'h20, 32'h70F);
    chk({31'h0, timer_irq}, 32'h1);
    bus(1'b1, 6'h18, 32'h002);
    rd(6'h20, 32'h002);
    bus(1'b1, 6'h18, 32'h004);
    rd(6'h20, 32'h004);
    bus(1'b1, 6'h18, 32'h70F);
    bus(1'b1, 6'h24, 32'h0);
    byteenable <= 4'h1;
    bus(1'b1, 6'h24, 32'h700);
    byteenable <= 4'hF;
    rd(6'h1C, 32'h70F);
    bus(1'b1, 6'h24, 32'h004);
    rd(6'h20, 32'h70B);
    chk({21'h0, timer_masked_interrupt_status}, 32'h70B);
    bus(1'b1, 6'h24, 32'hFFFF_FFFF);
    rd(6'h1C, 32'h0);
    chk({31'h0, timer_irq}, 32'h0);
    bus(1'b1, 6'h18, 32'h0);
    ev(11'h002);
    rd(6'h1C, 32'h002);
    rd(6'h20, 32'h0);
    rd(6'h30, 32'h70F);
    rd(6'h30, 32'h0);
    bus(1'b1, 6'h34, 32'h002);
    ev(11'h003);
    rd(6'h3C, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(6'h30, 32'h003);
    chk({31'h0, irq}, 32'h0);
    rd(6'h30, 32'h0);
    chk({31'h0, irq}, 32'h0);
    end_sim;
  end
endmodule
bind timer_interrupt_status_clear tisc_chk chk_i (.ref_clk, .rstn,
  .address, .read, .write, .byteenable, .writedata, .readdata,
  .waitrequest, .source_event, .timer_masked_interrupt_status, .timer_irq);
`default_nettype wire
